// file: lookup_entry_pkg.sv
package lookup_entry_pkg;

   // ==========================================================
   // Register map
   localparam logic [15:0] CMD_ADDR    = 16'h1800;
   localparam logic [15:0] LOWER_ADDR  = 16'h1801;
   localparam logic [15:0] UPPER_ADDR  = 16'h1802;
   localparam logic [15:0] STATUS_ADDR = 16'h1803;

   // ==========================================================
   // Field positions of the upper staging, command and status registers
   localparam int VALID_BIT   = 24;
   localparam int AGE_BIT     = 23;
   localparam int STATIC_BIT  = 22;
   localparam int FILTER_BIT  = 21;
   localparam int PRIO_HI     = 20;
   localparam int PRIO_LO     = 19;
   localparam int PORT_HI     = 18;
   localparam int PORT_LO     = 16;
   localparam int MAC_HI_MSB  = 15;
   localparam int UPPER_W     = 25;
   localparam int MAKE_BIT    = 2;
   localparam int BUSY_BIT    = 0;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   // ==========================================================
   // Aging timing: one sweep every half of the aging span
   localparam longint unsigned AGE_HALF_S = 300;
   localparam longint unsigned CLK_HZ     = 200_000_000;
   localparam longint unsigned AGE_HALF_CYCLES = AGE_HALF_S * CLK_HZ;

   // ==========================================================
   // Types
   typedef struct packed {
      logic        valid;
      logic        age;
      logic        stat;
      logic        filter;
      logic [1:0]  prio;
      logic [2:0]  port;
      logic [47:0] mac;
   } entry_t;

   typedef struct packed {
      logic       hit;
      logic       filter;
      logic       override;
      logic       prio_used;
      logic [1:0] prio;
      logic [2:0] ports;
   } lookup_result_t;

   typedef enum logic [0:0] {
      ST_IDLE  = 1'b0,
      ST_CHECK = 1'b1
   } fsm_t;

   typedef enum logic [1:0] {
      OP_MAKE  = 2'b00,
      OP_SRC   = 2'b01,
      OP_DST   = 2'b10,
      OP_SWEEP = 2'b11
   } op_t;

endpackage

// file: lookup_table_mem.sv
`timescale 1ns/1ps
module lookup_table_mem #(
   parameter int WIDTH = 57,
   parameter int DEPTH = 1024
) (
   // Clock
   input  wire logic                     core_clk_i,
   // Write port
   input  wire logic                     we_i,
   input  wire logic [$clog2(DEPTH)-1:0] addr_i,
   input  wire logic [WIDTH-1:0]         wdata_i,
   // Registered read data
   output logic      [WIDTH-1:0]         rdata_o
);

   // ==========================================================
   // Storage
   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
      rdata_o <= mem_q[addr_i];
   end

endmodule

// file: lookup_entry_regs.sv
`timescale 1ns/1ps
// Overview of operation
// RQ1: Valid bit commits or invalidates matching entry
// RQ2: Software sets age bit for non-static entries
// RQ3: Static with age bit overrides port state
// RQ4: Static entries never aged nor relearned
// RQ5: Non-static idle entries removed after 5-10 minutes
// RQ6: Software clears static when removing entries
// RQ7: Filter bit drops destination-matching packets
// RQ8: Priority used only static and priority-first
// RQ9: Port field decodes to port sets
// RQ10: Upper sixteen bits hold last MAC bits
// RQ11: Commit happens only on Make Entry
// RQ12: Table picks slot, busy flag reports completion
// RQ13: Lower register holds first 32 MAC bits
// RQ14: Reserved bits zero, fields hold until written
module lookup_entry_regs #(
   parameter int              DEPTH      = 1024,
   parameter longint unsigned AGE_CYCLES =
      lookup_entry_pkg::AGE_HALF_CYCLES
) (
   // Clock and reset
   input  wire logic                         core_clk_i,
   input  wire logic                         reset_i,
   // Register port
   input  wire logic [15:0]                  reg_addr_i,
   input  wire logic [31:0]                  reg_wdata_i,
   input  wire logic                         reg_wr_i,
   input  wire logic                         reg_rd_i,
   output logic      [31:0]                  reg_rdata_o,
   // Global configuration
   input  wire logic                         dest_prio_first_i,
   // Lookup port
   input  wire logic                         lkp_req_i,
   input  wire logic                         lkp_src_i,
   input  wire logic [47:0]                  lkp_mac_i,
   output logic                              lkp_ready_o,
   output logic                              lkp_done_o,
   output lookup_entry_pkg::lookup_result_t  lkp_result_o
);

   localparam int IDX_W = $clog2(DEPTH);
   localparam int AGE_W = $clog2(AGE_CYCLES + 1);
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);
   localparam logic [AGE_W-1:0] AGE_LAST = AGE_W'(AGE_CYCLES - 1);

   // ==========================================================
   // Parameter checks
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
      $error("DEPTH must be a power of two");
   end
   if (AGE_CYCLES < 4 * DEPTH) begin : g_age_chk
      $error("AGE_CYCLES too short for a sweep");
   end

   // ==========================================================
   // State
   typedef struct packed {
      logic [31:0]                      lower;
      logic [24:0]                      upper;
      logic                             make_cmd;
      logic                             busy;
      lookup_entry_pkg::fsm_t           fsm;
      lookup_entry_pkg::op_t            op;
      logic [IDX_W-1:0]                 idx;
      logic [47:0]                      cur_mac;
      logic                             clearing;
      logic                             sweep_pend;
      logic [AGE_W-1:0]                 age_cnt;
      logic [31:0]                      rdata;
      logic                             done;
      lookup_entry_pkg::lookup_result_t result;
   } state_t;

   state_t                   s_q;
   state_t                   s_d;
   logic                     mem_we;
   logic [IDX_W-1:0]         mem_addr;
   lookup_entry_pkg::entry_t mem_wdata;
   lookup_entry_pkg::entry_t mem_rdata;
   lookup_entry_pkg::entry_t staged;
   logic                     match;

   // ==========================================================
   // Functions
   function automatic logic [IDX_W-1:0] hash_mac(logic [47:0] mac);
      logic [IDX_W-1:0] h;
      h = '0;
      for (int i = 0; i < 48; i++) begin
         h[i % IDX_W] = h[i % IDX_W] ^ mac[i];
      end
      return h;
   endfunction

   function automatic logic [2:0] port_mask(logic [2:0] code);
      logic [2:0] m;
      m = 3'h0;
      unique case (code)
         3'h0: m = 3'h1;
         3'h1: m = 3'h2;
         3'h2: m = 3'h4;
         3'h3: m = 3'h0;
         3'h4: m = 3'h3;
         3'h5: m = 3'h5;
         3'h6: m = 3'h6;
         3'h7: m = 3'h7;
      endcase
      return m;
   endfunction

   // ==========================================================
   // Entry assembled from the staging registers
   always_comb begin
      staged        = '0;
      staged.valid  = s_q.upper[lookup_entry_pkg::VALID_BIT];    // [RQ1]
      staged.age    = s_q.upper[lookup_entry_pkg::AGE_BIT];
      staged.stat   = s_q.upper[lookup_entry_pkg::STATIC_BIT];
      staged.filter = s_q.upper[lookup_entry_pkg::FILTER_BIT];
      staged.prio   = s_q.upper[lookup_entry_pkg::PRIO_HI:
                                lookup_entry_pkg::PRIO_LO];
      staged.port   = s_q.upper[lookup_entry_pkg::PORT_HI:
                                lookup_entry_pkg::PORT_LO];
      staged.mac    = {s_q.upper[lookup_entry_pkg::MAC_HI_MSB:0],
                       s_q.lower};                          // [RQ10] [RQ13]
   end

   assign match = mem_rdata.valid && (mem_rdata.mac == s_q.cur_mac);

   // ==========================================================
   // Next state
   always_comb begin
      s_d       = s_q;
      s_d.done  = 1'b0;
      s_d.rdata = '0;
      mem_we    = 1'b0;
      mem_addr  = s_q.idx;
      mem_wdata = '0;
      unique case (s_q.fsm)
         lookup_entry_pkg::ST_IDLE: begin
            if (s_q.clearing) begin
               mem_we  = 1'b1;
               s_d.idx = s_q.idx + 1'b1;
               if (s_q.idx == IDX_LAST) begin
                  s_d.clearing = 1'b0;
               end
            end else if (s_q.busy) begin
               s_d.cur_mac = staged.mac;
               mem_addr    = hash_mac(staged.mac);               // [RQ12]
               s_d.op      = lookup_entry_pkg::OP_MAKE;
               s_d.fsm     = lookup_entry_pkg::ST_CHECK;
            end else if (s_q.sweep_pend) begin
               s_d.op  = lookup_entry_pkg::OP_SWEEP;
               s_d.fsm = lookup_entry_pkg::ST_CHECK;
            end else if (lkp_req_i) begin
               s_d.cur_mac = lkp_mac_i;
               mem_addr    = hash_mac(lkp_mac_i);
               s_d.op      = lkp_src_i ? lookup_entry_pkg::OP_SRC
                                       : lookup_entry_pkg::OP_DST;
               s_d.fsm     = lookup_entry_pkg::ST_CHECK;
            end
         end
         lookup_entry_pkg::ST_CHECK: begin
            s_d.fsm  = lookup_entry_pkg::ST_IDLE;
            mem_addr = hash_mac(s_q.cur_mac);
            unique case (s_q.op)
               lookup_entry_pkg::OP_MAKE: begin
                  s_d.busy = 1'b0;                               // [RQ12]
                  if (staged.valid) begin
                     mem_we    = 1'b1;                     // [RQ1] [RQ11]
                     mem_wdata = staged;
                  end else if (match) begin
                     mem_we = 1'b1;                              // [RQ1]
                  end
               end
               lookup_entry_pkg::OP_SRC: begin
                  s_d.done = 1'b1;
                  if (match && !mem_rdata.stat && !mem_rdata.age) begin
                     mem_we        = 1'b1;                       // [RQ4]
                     mem_wdata     = mem_rdata;
                     mem_wdata.age = 1'b1;
                  end
               end
               lookup_entry_pkg::OP_DST: begin
                  s_d.done            = 1'b1;
                  s_d.result          = '0;
                  s_d.result.hit      = match;
                  s_d.result.filter   = match && mem_rdata.filter;  // [RQ7]
                  s_d.result.override = match && mem_rdata.stat &&
                                        mem_rdata.age;           // [RQ3]
                  s_d.result.prio_used = match && mem_rdata.stat &&
                                         dest_prio_first_i;      // [RQ8]
                  s_d.result.prio     = match ? mem_rdata.prio : 2'h0;
                  s_d.result.ports    = match ? port_mask(mem_rdata.port)
                                              : 3'h0;            // [RQ9]
               end
               lookup_entry_pkg::OP_SWEEP: begin
                  mem_addr = s_q.idx;
                  s_d.idx  = s_q.idx + 1'b1;
                  if (s_q.idx == IDX_LAST) begin
                     s_d.sweep_pend = 1'b0;
                  end
                  if (mem_rdata.valid && !mem_rdata.stat) begin  // [RQ4]
                     mem_we = 1'b1;                              // [RQ5]
                     if (mem_rdata.age) begin
                        mem_wdata     = mem_rdata;
                        mem_wdata.age = 1'b0;
                     end
                  end
               end
            endcase
         end
      endcase
      // Register writes; a new make request wins over busy clearing
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            lookup_entry_pkg::LOWER_ADDR: s_d.lower = reg_wdata_i; // [RQ13]
            lookup_entry_pkg::UPPER_ADDR: begin
               s_d.upper = reg_wdata_i[lookup_entry_pkg::UPPER_W-1:0];
            end                                                  // [RQ14]
            lookup_entry_pkg::CMD_ADDR: begin
               s_d.make_cmd = reg_wdata_i[lookup_entry_pkg::MAKE_BIT];
               if (reg_wdata_i[lookup_entry_pkg::MAKE_BIT] &&
                   !s_q.make_cmd) begin
                  s_d.busy = 1'b1;                               // [RQ11]
               end
            end
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            lookup_entry_pkg::LOWER_ADDR: s_d.rdata = s_q.lower;
            lookup_entry_pkg::UPPER_ADDR: begin
               s_d.rdata = 32'(s_q.upper);                       // [RQ14]
            end
            lookup_entry_pkg::CMD_ADDR: begin
               s_d.rdata[lookup_entry_pkg::MAKE_BIT] = s_q.make_cmd;
            end
            lookup_entry_pkg::STATUS_ADDR: begin
               s_d.rdata[lookup_entry_pkg::BUSY_BIT] = s_q.busy; // [RQ12]
            end
            default: ;
         endcase
      end
      // Aging tick; its set wins over the sweep end
      if (s_q.age_cnt == AGE_LAST) begin
         s_d.age_cnt    = '0;
         s_d.sweep_pend = 1'b1;                                  // [RQ5]
      end else begin
         s_d.age_cnt = s_q.age_cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_q          <= '0;
         s_q.clearing <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Table storage
   lookup_table_mem #(
      .WIDTH ($bits(lookup_entry_pkg::entry_t)),
      .DEPTH (DEPTH)
   ) u_mem (
      .core_clk_i (core_clk_i),
      .we_i       (mem_we),
      .addr_i     (mem_addr),
      .wdata_i    (mem_wdata),
      .rdata_o    (mem_rdata)
   );

   // ==========================================================
   // Outputs
   assign reg_rdata_o  = s_q.rdata;
   assign lkp_done_o   = s_q.done;
   assign lkp_result_o = s_q.result;
   assign lkp_ready_o  = (s_q.fsm == lookup_entry_pkg::ST_IDLE) &&
                         !s_q.clearing && !s_q.busy && !s_q.sweep_pend;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   reserved_read_zero_a: assert property (                       // [RQ14]
      reg_rd_i && reg_addr_i == lookup_entry_pkg::UPPER_ADDR
      |=> reg_rdata_o[31:lookup_entry_pkg::UPPER_W] == '0)
      else $error("reserved bits not zero");
   upper_hold_a: assert property (                               // [RQ14]
      !(reg_wr_i && reg_addr_i == lookup_entry_pkg::UPPER_ADDR)
      |=> $stable(s_q.upper))
      else $error("upper register changed without write");
   make_cause_a: assert property (                               // [RQ11]
      $rose(s_q.busy) |-> $past(reg_wr_i) &&
      $past(reg_addr_i) == lookup_entry_pkg::CMD_ADDR)
      else $error("commit started without command");
   make_done_a: assert property (                                // [RQ12]
      $rose(s_q.busy) && !s_q.clearing |-> ##[1:4] !s_q.busy)
      else $error("make not completed in time");
   commit_valid_a: assert property (                             // [RQ1]
      mem_we && s_q.fsm == lookup_entry_pkg::ST_CHECK &&
      s_q.op == lookup_entry_pkg::OP_MAKE
      |-> mem_wdata.valid == s_q.upper[lookup_entry_pkg::VALID_BIT])
      else $error("committed valid bit wrong");
   commit_mac_a: assert property (                          // [RQ10] [RQ13]
      mem_we && mem_wdata.valid && s_q.op == lookup_entry_pkg::OP_MAKE
      |-> mem_wdata.mac == {s_q.upper[lookup_entry_pkg::MAC_HI_MSB:0],
                            s_q.lower})
      else $error("committed MAC wrong");
   static_kept_a: assert property (                              // [RQ4]
      mem_we && s_q.fsm == lookup_entry_pkg::ST_CHECK &&
      s_q.op != lookup_entry_pkg::OP_MAKE |-> !mem_rdata.stat)
      else $error("static entry altered");
   filter_hit_a: assert property (                               // [RQ7]
      lkp_done_o && lkp_result_o.filter |-> lkp_result_o.hit)
      else $error("filter without hit");
   prio_gate_a: assert property (                                // [RQ8]
      s_d.done && s_d.result.prio_used |-> dest_prio_first_i
      ##1 lkp_result_o.prio_used)
      else $error("priority used without global setting");
   miss_ports_a: assert property (                               // [RQ9]
      lkp_done_o && !lkp_result_o.hit |-> lkp_result_o.ports == 3'h0)
      else $error("ports on miss");
   age_tick_a: assert property (                                 // [RQ5]
      $rose(s_q.sweep_pend) |-> $past(s_q.age_cnt) == AGE_LAST)
      else $error("sweep started off the aging tick");

   make_seen_c:  cover property ($fell(s_q.busy));
   dst_hit_c:    cover property (lkp_done_o && lkp_result_o.hit);
   sweep_del_c:  cover property (mem_we && s_q.op ==
                                 lookup_entry_pkg::OP_SWEEP && !mem_rdata.age);

endmodule

// file: lookup_entry_regs_tb.sv
`timescale 1ns/1ps
module lookup_entry_regs_tb;
   // ==========================================================
   // Settings and signals
   localparam int              DEPTH = 16;
   localparam longint unsigned AGE   = 64;
   localparam logic [2:0] PMAP [8] =
      '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
   localparam logic [31:0] LO_A = 32'h0000_0001;

   logic                             core_clk_i = 1'b0;
   logic                             reset_i = 1'b1;
   logic [15:0]                      reg_addr_i = 16'h0000;
   logic [31:0]                      reg_wdata_i = 32'h0000_0000;
   logic                             reg_wr_i = 1'b0;
   logic                             reg_rd_i = 1'b0;
   logic [31:0]                      reg_rdata_o;
   logic                             dest_prio_first_i = 1'b0;
   logic                             lkp_req_i = 1'b0;
   logic                             lkp_src_i = 1'b0;
   logic [47:0]                      lkp_mac_i = 48'h0;
   logic                             lkp_ready_o;
   logic                             lkp_done_o;
   lookup_entry_pkg::lookup_result_t lkp_result_o;
   int                               error_cnt = 0;
   int                               check_count = 0;

   lookup_entry_regs #(.DEPTH(DEPTH), .AGE_CYCLES(AGE)) lookup_entry_regs_i (
      .core_clk_i(core_clk_i), .reset_i(reset_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .dest_prio_first_i(dest_prio_first_i),
      .lkp_req_i(lkp_req_i), .lkp_src_i(lkp_src_i), .lkp_mac_i(lkp_mac_i),
      .lkp_ready_o(lkp_ready_o), .lkp_done_o(lkp_done_o),
      .lkp_result_o(lkp_result_o));

   always #2.5 core_clk_i = ~core_clk_i;

   // ==========================================================
   // Shared tasks
   task automatic finish_test();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   task automatic make(input logic [31:0] lo, input logic [31:0] up);
      logic [31:0] d;
      int          n;
      wr(lookup_entry_pkg::LOWER_ADDR, lo);
      wr(lookup_entry_pkg::UPPER_ADDR, up);
      wr(lookup_entry_pkg::CMD_ADDR, 32'h0000_0004);
      rd(lookup_entry_pkg::STATUS_ADDR, d);
      check(d, 32'h0000_0001);
      n = 0;
      while (d[0] !== 1'b0 && n < 4 * DEPTH) begin
         rd(lookup_entry_pkg::STATUS_ADDR, d);
         n++;
      end
      check(d, 32'h0000_0000);
      wr(lookup_entry_pkg::CMD_ADDR, 32'h0000_0000);
   endtask

   task automatic lookup(input logic src, input logic [47:0] mac,
                         output logic [31:0] r);
      int n;
      @(posedge core_clk_i);
      lkp_req_i <= 1'b1;
      lkp_src_i <= src;
      lkp_mac_i <= mac;
      n = 0;
      @(negedge core_clk_i);
      while (lkp_ready_o !== 1'b1 && n < 4 * DEPTH + 300) begin
         @(negedge core_clk_i);
         n++;
      end
      @(posedge core_clk_i);
      lkp_req_i <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk_i);
         #1 n++;
      end while (lkp_done_o !== 1'b1 && n < 8);
      check({31'h0, lkp_done_o}, 32'h1);
      r = {23'h0, lkp_result_o};
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset_regs();
      logic [31:0] d;
      logic [15:0] a;
      for (int i = 0; i < 5; i++) begin
         a = 16'h1800 + 16'(i);
         rd(a, d);
         check(d, lookup_entry_pkg::RESET_WORD);
      end
      check({31'h0, lkp_ready_o}, 32'h0);
   endtask

   task automatic t_reg_access();
      logic [31:0] d;
      wr(lookup_entry_pkg::UPPER_ADDR, 32'hffff_ffff);
      rd(lookup_entry_pkg::UPPER_ADDR, d);
      check(d, 32'h01ff_ffff);
      wr(lookup_entry_pkg::LOWER_ADDR, 32'ha5a5_5a5a);
      wr(16'h1804, 32'hffff_ffff);
      wr(lookup_entry_pkg::STATUS_ADDR, 32'hffff_ffff);
      rd(lookup_entry_pkg::LOWER_ADDR, d);
      check(d, 32'ha5a5_5a5a);
      rd(16'h1804, d);
      check(d, 32'h0000_0000);
      rd(lookup_entry_pkg::STATUS_ADDR, d);
      check(d, 32'h0000_0000);
      rd(lookup_entry_pkg::UPPER_ADDR, d);
      check(d, 32'h01ff_ffff);
   endtask

   task automatic t_fields();
      logic [31:0] r;
      logic [2:0]  c;
      logic [31:0] up;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         @(posedge core_clk_i);
         dest_prio_first_i <= c[2];
         up = {7'h0, 1'b1, c[0], 1'b1, c[1], c[1:0], c, 16'hbeef};
         make(LO_A, up);
         lookup(1'b0, {16'hbeef, LO_A}, r);
         check(r, {23'h0, 1'b1, c[1], c[0], c[2],
                   c[1:0], PMAP[i]});
      end
      make(LO_A, {7'h0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h3, 3'h7, 16'hbeef});
      lookup(1'b0, {16'hbeef, LO_A}, r);
      check(r, {23'h0, 1'b1, 3'b000, 2'h3, 3'h7});
      @(posedge core_clk_i);
      dest_prio_first_i <= 1'b0;
   endtask

   task automatic t_mac_bits();
      logic [31:0] r;
      make(32'h0000_0100, {7'h0, 3'b101, 1'b0, 2'h0, 3'h1, 16'h8001});
      lookup(1'b0, {16'h8001, 32'h0000_0100}, r);
      check(r, {23'h0, 4'b1000, 2'h0, 3'h2});
      lookup(1'b0, {16'h0001, 32'h0000_0100}, r);
      check({31'h0, r[8]}, 32'h0);
      lookup(1'b0, {16'h8001, 32'h0000_0101}, r);
      check({31'h0, r[8]}, 32'h0);
      wr(lookup_entry_pkg::UPPER_ADDR, 32'h01ff_8001);
      wr(lookup_entry_pkg::LOWER_ADDR, 32'h0000_0100);
      lookup(1'b0, {16'h8001, 32'h0000_0100}, r);
      check(r, {23'h0, 4'b1000, 2'h0, 3'h2});
      make(32'h0000_0100, {7'h0, 3'b000, 1'b0, 2'h0, 3'h1, 16'h8001});
      lookup(1'b0, {16'h8001, 32'h0000_0100}, r);
      check({31'h0, r[8]}, 32'h0);
   endtask

   task automatic t_aging();
      logic [31:0] r;
      make(32'h0000_0011, {7'h0, 3'b111, 1'b0, 2'h0, 3'h1, 16'h0000});
      make(32'h0000_0012, {7'h0, 3'b110, 1'b0, 2'h0, 3'h1, 16'h0000});
      make(32'h0000_0014, {7'h0, 3'b110, 1'b0, 2'h0, 3'h2, 16'h0000});
      lookup(1'b0, {16'h0, 32'h0000_0012}, r);
      check({31'h0, r[8]}, 32'h1);
      for (int i = 0; i < 10; i++) begin
         repeat (32) @(posedge core_clk_i);
         lookup(1'b1, {16'h0, 32'h0000_0014}, r);
      end
      lookup(1'b0, {16'h0, 32'h0000_0012}, r);
      check({31'h0, r[8]}, 32'h0);
      lookup(1'b0, {16'h0, 32'h0000_0011}, r);
      check(r, {23'h0, 4'b1010, 2'h0, 3'h2});
      lookup(1'b0, {16'h0, 32'h0000_0014}, r);
      check({31'h0, r[8]}, 32'h1);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (16) @(posedge core_clk_i);
      reset_i <= 1'b0;
      t_reset_regs();
      t_reg_access();
      t_fields();
      t_mac_bits();
      t_aging();
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge core_clk_i);
      error_cnt++;
      $display("BAD %0t watchdog expired", $time);
      finish_test();
   end
endmodule
